// ### rtl/tsm_pkg.sv
package tsm_pkg;
	// smbus slave address: fixed upper bits and selectable lower bits
	localparam logic [2:0] TSM_ADDR_FIXED     = 3'h4;
	localparam logic [3:0] TSM_ADDR_SELECT    = 4'he;
	// sensor_mode_config layout and reset value
	localparam int         TSM_ALERT_SUPPRESS_BIT = 7;
	localparam int         TSM_STANDBY_SELECT_BIT = 6;
	localparam logic [7:0] TSM_CONFIG_RESET   = 8'h00;
	localparam logic [7:0] TSM_CONFIG_WMASK   = 8'hc0;
	// command codes of this sensor (byte-data command field)
	localparam logic [7:0] TSM_CMD_CONFIG_RD  = 8'h03;
	localparam logic [7:0] TSM_CMD_CONFIG_WR  = 8'h09;
	localparam logic [7:0] TSM_CMD_ONE_SHOT   = 8'h0f;
	// smbus wires pass this many sampling stages on clock_i; edges are seen on the last two
	localparam int         TSM_FILTER_LEN     = 3;
	typedef enum logic [2:0] {
		TSM_IDLE,
		TSM_ADDR,
		TSM_CMD,
		TSM_WDATA,
		TSM_RDATA,
		TSM_ACK_TX,
		TSM_ACK_RX
	} tsm_bus_state_type;
endpackage

// ### rtl/tsm_convert.sv
`timescale 1ns/1ps
// conversion engine sequencing: continuous or one-shot conversion slots
module tsm_convert
#(
	parameter int CONV_CYCLES = 16
)
(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// mode and commands
	input  wire logic standby_i,
	input  wire logic one_shot_i,
	// conversion status
	output logic      busy_o,
	output logic      done_o
);
	import tsm_pkg::*;

	logic [$clog2(CONV_CYCLES+1)-1:0] count_r;
	logic                             pend_r;
	logic                             last_w;

	// final cycle of a conversion slot
	assign last_w = count_r == $bits(count_r)'(CONV_CYCLES - 1);

	// a one-shot shields its own slot from the standby abort and is dropped when that slot ends,
	// so it cannot restart the engine; a second command inside the slot is absorbed unless it comes on the slot's last cycle
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			pend_r <= 1'b0;
		else if (!standby_i)
			pend_r <= 1'b0;
		else if (one_shot_i)
			pend_r <= 1'b1;
		else if (busy_o && last_w)
			pend_r <= 1'b0;
	end

	// conversion counter; standby entry aborts at once
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			busy_o  <= 1'b0;
			done_o  <= 1'b0;
			count_r <= '0;
		end
		else
		begin
			done_o <= 1'b0;
			if (standby_i && busy_o && !pend_r)
			begin
				busy_o  <= 1'b0;
				count_r <= '0;
			end
			else if (busy_o)
			begin
				if (last_w)
				begin
					busy_o  <= 1'b0;
					done_o  <= 1'b1;
					count_r <= '0;
				end
				else
					count_r <= count_r + 1'b1;
			end
			else if (!standby_i || pend_r || one_shot_i)
				busy_o <= 1'b1;
		end
	end
endmodule

// ### rtl/tsm_top.sv
`timescale 1ns/1ps
module tsm_top
#(
	parameter int CONV_CYCLES = 16
)
(
	// clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// smbus pins (open drain)
	input  wire logic smb_clk_i,
	input  wire logic smb_dat_i,
	output logic      smb_dat_o,
	output logic      smb_dat_oe_o,
	// temperature comparison from the measuring front end
	input  wire logic temp_above_high_i,
	input  wire logic temp_below_low_i,
	// alert pin, active low open drain
	output logic      smb_alert_n_o,
	output logic      smb_alert_oe_o,
	// engine status
	output logic      conv_busy_o,
	output logic      conv_done_o,
	output logic      standby_o
);
	import tsm_pkg::*;

	logic [7:0]        sensor_mode_config_r;
	logic [7:0]        sensor_mode_config_nxt;
	localparam int     TAP = TSM_FILTER_LEN - 1;
	logic [TAP:0]      scl_r;
	logic [TAP:0]      sda_r;
	tsm_bus_state_type state_r;
	logic [3:0]        bit_r;
	logic [7:0]        shift_r;
	logic [7:0]        cmd_r;
	logic              rd_r;
	logic              one_shot_r;
	logic              alert_ev_r;
	tsm_bus_state_type after_ack_r;

	wire scl_rise = !scl_r[TAP] && scl_r[TAP-1];
	wire scl_fall = scl_r[TAP] && !scl_r[TAP-1];
	wire start_c  = scl_r[TAP] && sda_r[TAP] && !sda_r[TAP-1];
	wire stop_c   = scl_r[TAP] && !sda_r[TAP] && sda_r[TAP-1];

	// decode helper used for address match
	function automatic logic addr_hit(input logic [6:0] a);
		addr_hit = a == {TSM_ADDR_FIXED, TSM_ADDR_SELECT};
	endfunction

	// sample pins; edge logic compares the second and third stages, first stage only feeds the next
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			scl_r <= '1;
			sda_r <= '1;
		end
		else
		begin
			scl_r <= {scl_r[TAP-1:0], smb_clk_i};
			sda_r <= {sda_r[TAP-1:0], smb_dat_i};
		end
	end

	// smbus byte protocol slave
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_r      <= TSM_IDLE;
			bit_r        <= 4'h0;
			shift_r      <= 8'h00;
			cmd_r        <= 8'h00;
			rd_r         <= 1'b0;
			after_ack_r  <= TSM_IDLE;
			smb_dat_o    <= 1'b1;
			smb_dat_oe_o <= 1'b0;
			one_shot_r   <= 1'b0;
			sensor_mode_config_r <= TSM_CONFIG_RESET;
		end
		else
		begin
			one_shot_r <= 1'b0;
			sensor_mode_config_r <= sensor_mode_config_nxt;
			if (start_c)
			begin
				state_r      <= TSM_ADDR;
				bit_r        <= 4'h0;
				smb_dat_oe_o <= 1'b0;
			end
			else if (stop_c)
			begin
				state_r      <= TSM_IDLE;
				smb_dat_oe_o <= 1'b0;
			end
			else
				case (state_r)
				TSM_ADDR, TSM_CMD, TSM_WDATA:
					if (scl_rise)
					begin
						shift_r <= {shift_r[6:0], sda_r[TAP]};
						bit_r   <= bit_r + 4'h1;
					end
					else if (scl_fall && bit_r == 4'h8)
					begin
						bit_r <= 4'h0;
						if (state_r == TSM_ADDR)
						begin
							if (addr_hit(shift_r[7:1]))
							begin
								rd_r         <= shift_r[0];
								smb_dat_o    <= 1'b0;
								smb_dat_oe_o <= 1'b1;
								after_ack_r  <= shift_r[0] ? TSM_RDATA : TSM_CMD;
								state_r      <= TSM_ACK_TX;
							end
							else
								state_r <= TSM_IDLE;
						end
						else
						begin
							if (state_r == TSM_CMD)
							begin
								cmd_r      <= shift_r;
								one_shot_r <= shift_r == TSM_CMD_ONE_SHOT;
							end
							smb_dat_o    <= 1'b0;
							smb_dat_oe_o <= 1'b1;
							after_ack_r  <= TSM_WDATA;
							state_r      <= TSM_ACK_TX;
						end
					end
				TSM_ACK_TX:
					if (scl_fall)
					begin
						state_r <= after_ack_r;
						if (after_ack_r == TSM_RDATA)
						begin
							// unused bits read as zero; read returns config for any command
							shift_r      <= {sensor_mode_config_r[6:0], 1'b0};
							smb_dat_o    <= sensor_mode_config_r[7];
							smb_dat_oe_o <= !sensor_mode_config_r[7];
							bit_r        <= 4'h1;
						end
						else
							smb_dat_oe_o <= 1'b0;
					end
				TSM_RDATA:
					if (scl_fall)
					begin
						if (bit_r == 4'h8)
						begin
							smb_dat_oe_o <= 1'b0;
							state_r      <= TSM_ACK_RX;
						end
						else
						begin
							smb_dat_o    <= shift_r[7];
							smb_dat_oe_o <= !shift_r[7];
							shift_r      <= {shift_r[6:0], 1'b0};
							bit_r        <= bit_r + 4'h1;
						end
					end
				TSM_ACK_RX:
					if (scl_rise)
						state_r <= TSM_IDLE; // single byte read only
				default:
					state_r <= TSM_IDLE;
				endcase
		end
	end

	// config write lands when the data byte is acknowledged
	always_comb
	begin
		sensor_mode_config_nxt = sensor_mode_config_r;
		if (state_r == TSM_WDATA && scl_fall && bit_r == 4'h8 && !rd_r
			&& cmd_r == TSM_CMD_CONFIG_WR)
			sensor_mode_config_nxt = shift_r & TSM_CONFIG_WMASK;
	end

	// alert level from threshold compare; gated by suppress bit
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			alert_ev_r     <= 1'b0;
			smb_alert_n_o  <= 1'b1;
			smb_alert_oe_o <= 1'b0;
		end
		else
		begin
			alert_ev_r     <= temp_above_high_i || temp_below_low_i;
			smb_alert_n_o  <= 1'b0;
			smb_alert_oe_o <= alert_ev_r && !sensor_mode_config_r[TSM_ALERT_SUPPRESS_BIT];
		end
	end

	// engine sees standby_select straight from the register, so abort is immediate
	tsm_convert #(
		.CONV_CYCLES (CONV_CYCLES)
	) u_convert (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.standby_i  (sensor_mode_config_r[TSM_STANDBY_SELECT_BIT]),
		.one_shot_i (one_shot_r),
		.busy_o     (conv_busy_o),
		.done_o     (conv_done_o)
	);

	// mirror of mode for status
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			standby_o <= 1'b0;
		else
			standby_o <= sensor_mode_config_r[TSM_STANDBY_SELECT_BIT];
	end
endmodule

// ### dv/tsm_host.sv
`timescale 1ns/1ps
// smbus host; the data wire has a pull-up
module tsm_host
(
	// clock and wires
	input  wire logic clock_i,
	input  wire logic dev_low_i,
	output logic      scl_o = 1'b1,
	output logic      sda_o
);
	logic low_r = 1'b0;
	assign sda_o = !(low_r || dev_low_i === 1'b1);
	// a third of a bit, slow so the input filter sees clean edges
	task automatic hp();
		repeat (10) @(posedge clock_i);
	endtask
	// start is lv(0,1,0), stop is lv(1,0,1)
	task automatic lv(logic a, logic b, logic c);
		hp();
		low_r <= a;
		hp();
		scl_o <= 1'b1;
		hp();
		low_r <= b;
		hp();
		scl_o <= c;
	endtask
	// nine bits msb first; a one releases the wire
	task automatic xb(logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			hp();
			low_r <= !d[i];
			hp();
			scl_o <= 1'b1;
			hp();
			r[i] = sda_o;
			scl_o <= 1'b0;
		end
	endtask
endmodule

// ### dv/tsm_assertions.sv
`timescale 1ns/1ps
// port checks of tsm_top
module tsm_assertions
#(
	parameter int CONV_CYCLES = 16
)
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic smb_clk_i,
	input wire logic smb_dat_oe_o,
	input wire logic smb_dat_o,
	input wire logic temp_above_high_i,
	input wire logic temp_below_low_i,
	input wire logic smb_alert_oe_o,
	input wire logic conv_busy_o,
	input wire logic conv_done_o,
	input wire logic standby_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// entry into standby
	sequence s_stby;
		!standby_o ##1 standby_o;
	endsequence
	a_alert_cause: assert property ($rose(smb_alert_oe_o) |-> $past(temp_above_high_i || temp_below_low_i, 2))
		else $error("alert without cause");
	a_alert_quiet: assert property (!$past(temp_above_high_i || temp_below_low_i, 2) |-> !smb_alert_oe_o)
		else $error("alert held");
	a_auto_runs: assert property ($fell(conv_busy_o) && !standby_o |-> ##[1:3] (conv_busy_o || standby_o))
		else $error("auto stalled");
	a_stby_halt: assert property (s_stby |-> !conv_busy_o [*3])
		else $error("no halt");
	a_shot_once: assert property (standby_o && conv_done_o |=> !conv_busy_o [*8])
		else $error("extra conversion");
	a_done_pulse: assert property (conv_done_o |=> !conv_done_o)
		else $error("done too long");
	a_ack_edge: assert property ($changed(smb_dat_oe_o) |-> !smb_clk_i)
		else $error("drive with clock high");
	a_mode_apply: assert property ($changed(standby_o) |-> !smb_clk_i)
		else $error("mode off write");
	a_drive_low: assert property (smb_dat_oe_o |-> !smb_dat_o)
		else $error("open drain drives high");
endmodule
bind tsm_top tsm_assertions #(
	.CONV_CYCLES (CONV_CYCLES)
) u_chk (
	.clock_i           (clock_i),
	.rst_i             (rst_i),
	.smb_clk_i         (smb_clk_i),
	.smb_dat_oe_o      (smb_dat_oe_o),
	.smb_dat_o         (smb_dat_o),
	.temp_above_high_i (temp_above_high_i),
	.temp_below_low_i  (temp_below_low_i),
	.smb_alert_oe_o    (smb_alert_oe_o),
	.conv_busy_o       (conv_busy_o),
	.conv_done_o       (conv_done_o),
	.standby_o         (standby_o)
);

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import tsm_pkg::*;
	localparam logic [7:0] AW = {TSM_ADDR_FIXED, TSM_ADDR_SELECT, 1'b0};
	logic       clock_i = 1'b0;
	logic       rst_i = 1'b1;
	logic       temp_above_high_i = 1'b0;
	logic       temp_below_low_i = 1'b0;
	logic [7:0] exp_r = TSM_CONFIG_RESET;
	logic       smb_clk_i, smb_dat_i, smb_dat_o, smb_dat_oe_o, smb_alert_n_o, smb_alert_oe_o;
	logic       conv_busy_o, conv_done_o, standby_o;
	int         n_fail = 0, cmp_count = 0, n_done = 0, cyc = 0;
	// 25 mhz clock
	initial forever #20 clock_i = !clock_i;
	// design and host share the two wires
	tsm_top #(
		.CONV_CYCLES (16)
	) dut (
		.clock_i           (clock_i),
		.rst_i             (rst_i),
		.smb_clk_i         (smb_clk_i),
		.smb_dat_i         (smb_dat_i),
		.smb_dat_o         (smb_dat_o),
		.smb_dat_oe_o      (smb_dat_oe_o),
		.temp_above_high_i (temp_above_high_i),
		.temp_below_low_i  (temp_below_low_i),
		.smb_alert_n_o     (smb_alert_n_o),
		.smb_alert_oe_o    (smb_alert_oe_o),
		.conv_busy_o       (conv_busy_o),
		.conv_done_o       (conv_done_o),
		.standby_o         (standby_o)
	);
	tsm_host h (.clock_i(clock_i), .dev_low_i(smb_dat_oe_o), .scl_o(smb_clk_i), .sda_o(smb_dat_i));
	// conversion count and hang guard
	always @(posedge clock_i)
	begin
		n_done <= n_done + int'(conv_done_o === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 60000)
			finish_test();
	end
	// x or z never matches
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		n_fail += int'(g !== e);
		if (g !== e)
			$display("ERROR %s expected %h seen %h", n, e, g);
	endtask
	task automatic finish_test();
		n_fail += int'(cyc >= 60000);
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// only the two mode bits are kept
	function automatic logic [7:0] exp_cfg(logic [7:0] v);
		return {v[7:6], 6'h00};
	endfunction
	// one byte; a is the expected ninth bit
	task automatic tx(logic [7:0] d, logic a);
		logic [8:0] r;
		h.xb({d, 1'b1}, r);
		chk("ack", 8'(a), 8'(r[0]));
	endtask
	// one command, then a plain read back
	task automatic acc(logic [7:0] c, logic [7:0] v);
		logic [8:0] r;
		h.lv(1'b0, 1'b1, 1'b0);
		tx(AW, 1'b0);
		tx(c, 1'b0);
		if (c == TSM_CMD_CONFIG_WR)
			tx(v, 1'b0);
		exp_r = (c == TSM_CMD_CONFIG_WR) ? exp_cfg(v) : exp_r;
		h.lv(1'b1, 1'b0, 1'b1);
		h.lv(1'b0, 1'b1, 1'b0);
		tx(AW | 8'h01, 1'b0);
		h.xb(9'h1ff, r);
		h.lv(1'b1, 1'b0, 1'b1);
		chk("config", exp_r, r[8:1]);
	endtask
	// main sequence
	initial
	begin
		logic [7:0] v;
		int n0;
		void'($urandom(32'hca9b));
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		acc(TSM_CMD_CONFIG_RD, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			// the host keeps the unused field at zero on every write
			v = (i == 0) ? 8'h40 : (i == 1) ? 8'hc0 : 8'($urandom) & TSM_CONFIG_WMASK;
			acc(TSM_CMD_CONFIG_WR, v);
			chk("standby", 8'(v[6]), 8'(standby_o));
			{temp_above_high_i, temp_below_low_i} <= (i < 2) ? 2'b11 : 2'($urandom);
			repeat (4) @(posedge clock_i);
			chk("alert", 8'(!v[7] && (temp_above_high_i || temp_below_low_i)), 8'(smb_alert_oe_o));
			chk("alert_n", 8'h00, 8'(smb_alert_n_o));
		end
		$display("test config and alert done");
		acc(TSM_CMD_CONFIG_WR, 8'h80);
		acc(TSM_CMD_CONFIG_WR, 8'h40);
		chk("busy", 8'h00, 8'(conv_busy_o));
		n0 = n_done;
		acc(TSM_CMD_ONE_SHOT, 8'h00);
		chk("shots", 8'h01, 8'(n_done - n0));
		h.lv(1'b0, 1'b1, 1'b0);
		tx(AW ^ 8'h02, 1'b1);
		h.lv(1'b1, 1'b0, 1'b1);
		n0 = n_done;
		acc(TSM_CMD_CONFIG_WR, 8'h00);
		chk("auto", 8'h01, 8'(n_done > n0 + 3));
		$display("test modes done");
		finish_test();
	end
endmodule
